/* apm_cfg.svh */
`ifndef APM_CFG_SVH
`define APM_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define APM_OFS_CTRL      8'h00
`define APM_OFS_STATUS    8'h04
`define APM_OFS_RESULT    8'h08
`define APM_OFS_PINDIR    8'h0c
`define APM_OFS_ANASEL    8'h10

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define APM_B_DONE        0
`define APM_B_SAMP        1
`define APM_B_RCSEL       2
`define APM_B_IRQEN       3
`define APM_B_TRIG_LO     4
`define APM_B_TRIG_HI     7
`define APM_B_TENBIT      10
`define APM_B_IDLESTOP    13
`define APM_B_ON          15

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define APM_TRIG_AUTO     4'h7
`define APM_RST_PINDIR    16'hffff
`define APM_RST_ANASEL    16'hffff

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define APM_CLK_NS        10
`define APM_TAD_NS        300
`define APM_TAD_CYC       ((`APM_TAD_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)
`define APM_SAMPLE_TADS   14

`endif

/* apm_pkg.sv */
package apm_pkg;

    // Converter sequencing states
    typedef enum logic [1:0] {ST_OFF, ST_READY, ST_SAMPLE, ST_CONVERT} apm_state_e;

    // Classic wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } apm_wb_req_s;

    // Complete state of the controller
    typedef struct packed {
        apm_state_e  state;
        logic        module_on;
        logic        idle_stop_select;
        logic        rc_clock_select;
        logic        conv_irq_enable;
        logic        ten_bit;
        logic [3:0]  trigger_source_select;
        logic        done;
        logic        aborted;
        logic        self_off;
        logic [11:0] result;
        logic [11:0] sar_code;
        logic [3:0]  sar_idx;
        logic [15:0] diff_h;
        logic [15:0] span_h;
        logic [4:0]  tad_cnt;
        logic [3:0]  smp_cnt;
        logic [15:0] pin_dir;
        logic [15:0] ana_sel;
        logic        rc_s1;
        logic        rc_s2;
        logic        rc_s3;
        logic        ack;
        logic [31:0] rdata;
        logic        clk_en;
        logic        irq;
        logic        wake;
        logic        sample_on;
    } apm_state_s;

endpackage

/* apm_ctrl.sv */
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "apm_cfg.svh"
// How it works
// - Sleep without the RC clock stops the converter clock and holds it low.
// - Sleep aborts a running conversion unless the RC clock is selected.
// - An aborted conversion never resumes; a new sample is needed.
// - Sleep entry and exit leave all control settings untouched.
// - With RC clock, conversion runs in Sleep, sets done, stores result.
// - Interrupt enabled: conversion completion in Sleep or Idle raises a wake-up request.
// - Completion in Sleep with interrupt off switches converter off, module_on stays.
// - Trigger code 0111 is automatic and converts during Sleep.
// - Idle stop bit 13 clear: run in Idle, enabled interrupt wakes.
// - Idle stop bit set: halt in Idle, abort, no resume.
// - Module disable stops clocks, ignores writes, reads give invalid data.
// - Converter can be switched on only while module disable is clear.
// - Reset restores registers, switches converter off, aborts conversion.
// - Reset makes shared pins analog inputs with direction bits set.
// - Result word is not cleared by reset.
// - Code is input difference as fraction of reference difference.
// - 12-bit: step is span/4096, floor to zero, saturate at all ones.
// - 10-bit: step is span/1024, floor to zero, saturate at all ones.
module apm_ctrl
(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 srst,
    // Register bus
    input  wire apm_pkg::apm_wb_req_s wb_req,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // Power controller
    input  wire logic                 cpu_sleep,
    input  wire logic                 cpu_idle,
    input  wire logic                 module_disable_bit,
    output logic                      wake_req,
    // RC oscillator pin
    input  wire logic                 rc_osc_pin,
    // Sampled analog front end
    input  wire logic [15:0]          ain_diff,
    input  wire logic [15:0]          aref_span,
    output logic                      sample_switch,
    output logic                      conv_clk_en,
    output logic                      conv_done_irq,
    // Shared pins
    output logic [15:0]               pin_direction_bits,
    output logic [15:0]               analog_select
);
    import apm_pkg::*;

    apm_state_s  st_r;
    apm_state_s  st_nxt;
    logic        run;
    logic        tick;
    logic        done_evt;
    logic        acc;
    logic        wr;
    logic        busy;
    logic [11:0] trial;
    logic [27:0] lhs;
    logic [27:0] rhs;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt   = st_r;
        done_evt = 1'b0;
        trial    = 12'h000;
        lhs      = 28'h0000000;
        rhs      = 28'h0000000;

        // Two-flop synchroniser plus edge stage for the RC oscillator
        st_nxt.rc_s1 = rc_osc_pin;
        st_nxt.rc_s2 = st_r.rc_s1;
        st_nxt.rc_s3 = st_r.rc_s2;

        // Converter clock may run only when no power state blocks it
        run = st_r.module_on && !module_disable_bit && !st_r.self_off
              && !(cpu_sleep && !st_r.rc_clock_select)
              && !(cpu_idle && st_r.idle_stop_select);
        st_nxt.clk_en = run;
        busy = (st_r.state == ST_SAMPLE) || (st_r.state == ST_CONVERT);

        // Conversion clock tick from RC edge or from the system divider
        if (st_r.rc_clock_select)
        begin
            tick = run && st_r.rc_s2 && !st_r.rc_s3;
            st_nxt.tad_cnt = 5'h00;
        end
        else
        begin
            tick = run && (st_r.tad_cnt == 5'(`APM_TAD_CYC - 1));
            st_nxt.tad_cnt = (!run || tick) ? 5'h00 : st_r.tad_cnt + 5'h01;
        end

        // Bus access, acknowledged but otherwise ignored while the module is disabled
        st_nxt.ack = wb_req.cyc && wb_req.stb && !st_r.ack;
        acc = st_nxt.ack;
        wr  = acc && wb_req.we && (wb_req.sel[1:0] == 2'h3)
              && !module_disable_bit;

        // Register reads; disabled module returns zero as invalid data
        st_nxt.rdata = 32'h00000000;
        if (acc && !wb_req.we && !module_disable_bit)
        begin
            unique case (wb_req.adr)
                `APM_OFS_CTRL:
                begin
                    st_nxt.rdata[`APM_B_ON]       = st_r.module_on;
                    st_nxt.rdata[`APM_B_IDLESTOP] = st_r.idle_stop_select;
                    st_nxt.rdata[`APM_B_TENBIT]   = st_r.ten_bit;
                    st_nxt.rdata[`APM_B_TRIG_HI:`APM_B_TRIG_LO] = st_r.trigger_source_select;
                    st_nxt.rdata[`APM_B_IRQEN]    = st_r.conv_irq_enable;
                    st_nxt.rdata[`APM_B_RCSEL]    = st_r.rc_clock_select;
                    st_nxt.rdata[`APM_B_SAMP]     = (st_r.state == ST_SAMPLE);
                    st_nxt.rdata[`APM_B_DONE]     = st_r.done;
                end
                `APM_OFS_STATUS:
                    st_nxt.rdata[5:0] = {st_r.wake, st_r.self_off, st_r.aborted,
                                         run, st_r.state};
                `APM_OFS_RESULT:
                    st_nxt.rdata[11:0] = st_r.result;
                `APM_OFS_PINDIR:
                    st_nxt.rdata[15:0] = st_r.pin_dir;
                `APM_OFS_ANASEL:
                    st_nxt.rdata[15:0] = st_r.ana_sel;
                default:
                    st_nxt.rdata = 32'h00000000;
            endcase
        end

        // Register writes; hardware events below take priority
        if (wr)
        begin
            unique case (wb_req.adr)
                `APM_OFS_CTRL:
                begin
                    st_nxt.module_on        = wb_req.dat[`APM_B_ON];
                    st_nxt.idle_stop_select = wb_req.dat[`APM_B_IDLESTOP];
                    st_nxt.ten_bit          = wb_req.dat[`APM_B_TENBIT];
                    st_nxt.trigger_source_select =
                        wb_req.dat[`APM_B_TRIG_HI:`APM_B_TRIG_LO];
                    st_nxt.conv_irq_enable  = wb_req.dat[`APM_B_IRQEN];
                    st_nxt.rc_clock_select  = wb_req.dat[`APM_B_RCSEL];
                    if (!wb_req.dat[`APM_B_DONE])
                        st_nxt.done = 1'b0;
                    if (!wb_req.dat[`APM_B_DONE])
                        st_nxt.aborted = 1'b0;
                    // Software sample start from ready
                    if (wb_req.dat[`APM_B_SAMP] && st_r.state == ST_READY && run)
                    begin
                        st_nxt.state   = ST_SAMPLE;
                        st_nxt.smp_cnt = 4'h0;
                    end
                    // Manual trigger: clearing samp ends sampling after a full step
                    if (!wb_req.dat[`APM_B_SAMP] && st_r.state == ST_SAMPLE
                        && st_r.smp_cnt != 4'h0
                        && st_r.trigger_source_select != `APM_TRIG_AUTO)
                    begin
                        st_nxt.state    = ST_CONVERT;
                        st_nxt.diff_h   = ain_diff;
                        st_nxt.span_h   = aref_span;
                        st_nxt.sar_code = 12'h000;
                        st_nxt.sar_idx  = st_r.ten_bit ? 4'h9 : 4'hb;
                    end
                end
                `APM_OFS_PINDIR:
                    st_nxt.pin_dir = wb_req.dat[15:0];
                `APM_OFS_ANASEL:
                    st_nxt.ana_sel = wb_req.dat[15:0];
                default:
                    st_nxt.pin_dir = st_nxt.pin_dir;
            endcase
        end

        // Sequencer; power states only halt it, they never edit settings
        unique case (st_r.state)
            ST_OFF:
                if (st_r.module_on && !module_disable_bit)
                    st_nxt.state = ST_READY;
            ST_READY:
                // Automatic trigger samples on its own, also in Sleep
                if (run && st_r.trigger_source_select == `APM_TRIG_AUTO
                    && !st_r.done && !st_r.aborted)
                begin
                    st_nxt.state   = ST_SAMPLE;
                    st_nxt.smp_cnt = 4'h0;
                end
            ST_SAMPLE:
                if (tick)
                begin
                    st_nxt.smp_cnt = st_r.smp_cnt + 4'h1;
                    if (st_r.trigger_source_select == `APM_TRIG_AUTO
                        && st_r.smp_cnt == 4'(`APM_SAMPLE_TADS - 1))
                    begin
                        st_nxt.state    = ST_CONVERT;
                        st_nxt.diff_h   = ain_diff;
                        st_nxt.span_h   = aref_span;
                        st_nxt.sar_code = 12'h000;
                        st_nxt.sar_idx  = st_r.ten_bit ? 4'h9 : 4'hb;
                    end
                end
            ST_CONVERT:
                if (tick)
                begin
                    // One successive-approximation bit per conversion clock
                    trial = st_r.sar_code | (12'h001 << st_r.sar_idx);
                    lhs   = 28'(trial) * 28'(st_r.span_h);
                    rhs   = st_r.ten_bit ? (28'(st_r.diff_h) << 10)
                                         : (28'(st_r.diff_h) << 12);
                    if (lhs <= rhs)
                        st_nxt.sar_code = trial;
                    if (st_r.sar_idx == 4'h0)
                    begin
                        done_evt      = 1'b1;
                        st_nxt.state  = ST_READY;
                        st_nxt.result = st_nxt.sar_code;
                        st_nxt.done   = 1'b1;
                    end
                    else
                        st_nxt.sar_idx = st_r.sar_idx - 4'h1;
                end
        endcase

        // Any halt mid-sample or mid-conversion discards the partial work
        if (busy && !run)
        begin
            st_nxt.state    = ST_READY;
            st_nxt.aborted  = 1'b1;
            st_nxt.sar_code = 12'h000;
            done_evt        = 1'b0;
            st_nxt.done     = st_r.done;
            st_nxt.result   = st_r.result;
        end
        if (!st_nxt.module_on)
            st_nxt.state = ST_OFF;

        // Completion events: wake request or self switch-off in Sleep
        if (done_evt && st_r.conv_irq_enable && (cpu_sleep || cpu_idle))
            st_nxt.wake = 1'b1;
        else if (!cpu_sleep && !cpu_idle)
            st_nxt.wake = 1'b0;
        if (done_evt && cpu_sleep && !st_r.conv_irq_enable)
            st_nxt.self_off = 1'b1;
        else if (!cpu_sleep)
            st_nxt.self_off = 1'b0;
        st_nxt.irq = st_nxt.done && st_nxt.conv_irq_enable;

        // Sample switch is registered so the analog switch never sees a decode glitch
        st_nxt.sample_on = (st_nxt.state == ST_SAMPLE);

        // Synchronous reset; the result word keeps its contents
        if (srst)
        begin
            st_nxt          = '0;
            st_nxt.state    = ST_OFF;
            st_nxt.pin_dir  = `APM_RST_PINDIR;
            st_nxt.ana_sel  = `APM_RST_ANASEL;
            st_nxt.result   = st_r.result;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        st_r <= st_nxt;
    end

    // Outputs straight from the state register
    assign wb_dat_o           = st_r.rdata;
    assign wb_ack_o           = st_r.ack;
    assign wake_req           = st_r.wake;
    assign sample_switch      = st_r.sample_on;
    assign conv_clk_en        = st_r.clk_en;
    assign conv_done_irq      = st_r.irq;
    assign pin_direction_bits = st_r.pin_dir;
    assign analog_select      = st_r.ana_sel;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    AST_SLEEP_CLK_LOW: assert property (
        cpu_sleep && !st_r.rc_clock_select |=> !conv_clk_en)
        else $error("converter clock runs in sleep without rc clock");

    AST_SLEEP_ABORT: assert property (
        cpu_sleep && !st_r.rc_clock_select && busy |=>
            st_r.aborted && st_r.state != ST_SAMPLE && st_r.state != ST_CONVERT)
        else $error("conversion not aborted on sleep");

    AST_NO_RESUME: assert property (
        st_r.state == ST_CONVERT && $past(st_r.state) != ST_CONVERT
            |-> $past(st_r.state) == ST_SAMPLE && st_r.sar_code == 12'h000)
        else $error("conversion entered without a fresh sample");

    AST_REGS_KEPT: assert property (
        $changed(cpu_sleep) && !wr |=> $stable(st_r.trigger_source_select)
            && $stable(st_r.conv_irq_enable) && $stable(st_r.module_on))
        else $error("sleep transition changed registers");

    AST_DONE_SET: assert property (
        done_evt |=> st_r.done && st_r.state != ST_CONVERT)
        else $error("completion did not set done");

    AST_WAKE: assert property (
        done_evt && st_r.conv_irq_enable && cpu_sleep |=> wake_req)
        else $error("no wake request on completion");

    AST_SELF_OFF: assert property (
        done_evt && cpu_sleep && !st_r.conv_irq_enable && !wr
            |=> st_r.self_off && st_r.module_on ##1 !conv_clk_en || !cpu_sleep)
        else $error("converter not switched off after sleep completion");

    AST_PMD_WRITE: assert property (
        acc && wb_req.we && module_disable_bit |=> $stable(st_r.module_on)
            && $stable(st_r.pin_dir) && wb_dat_o == 32'h00000000)
        else $error("write accepted while module disabled");

    AST_RESET: assert property (disable iff (1'b0)
        srst |=> !st_r.module_on && st_r.state == ST_OFF
            && pin_direction_bits == 16'hffff)
        else $error("reset values wrong");

    AST_SATURATE: assert property (
        done_evt && !st_r.ten_bit && st_r.diff_h >= st_r.span_h |=> st_r.result == 12'hfff)
        else $error("12-bit code not saturated");

    AST_RC_SLEEP_RUN: assert property (
        cpu_sleep && st_r.rc_clock_select && st_r.module_on && !st_r.self_off
            && !module_disable_bit && !cpu_idle |=> conv_clk_en)
        else $error("rc clocked converter stopped in sleep");

    AST_IDLE_WAKE: assert property (
        done_evt && st_r.conv_irq_enable && cpu_idle && !st_r.idle_stop_select
            |=> wake_req)
        else $error("no wake request from idle");

    AST_IDLE_STOP: assert property (
        cpu_idle && st_r.idle_stop_select && busy
            |=> st_r.aborted && !sample_switch && st_r.state != ST_CONVERT)
        else $error("conversion not aborted on idle stop");

    AST_PMD_CLK: assert property (
        module_disable_bit |=> !conv_clk_en)
        else $error("converter clock runs while module disabled");

    AST_ON_GATED: assert property (
        module_disable_bit && !st_r.module_on |=> !st_r.module_on)
        else $error("converter switched on while module disabled");

    AST_SATURATE_TEN: assert property (
        done_evt && st_r.ten_bit && st_r.diff_h >= st_r.span_h
            |=> st_r.result == 12'h3ff)
        else $error("10-bit code not saturated");

    AST_RC_STEP: assert property (
        st_r.rc_clock_select && st_r.state == ST_SAMPLE
            && st_nxt.smp_cnt != st_r.smp_cnt |-> st_r.rc_s2 && !st_r.rc_s3)
        else $error("rc sample step without a synchronised edge");

    // Cover points for the main scenarios
    COV_MANUAL: cover property (wr && st_r.state == ST_SAMPLE ##1 st_r.state == ST_CONVERT);
    COV_SELF_OFF: cover property ($rose(st_r.self_off));
    COV_SLEEP_RC_DONE: cover property (cpu_sleep && st_r.rc_clock_select && done_evt);
    COV_SLEEP_ABORT: cover property (cpu_sleep && busy ##1 $rose(st_r.aborted));
    COV_IDLE_WAKE: cover property (cpu_idle && done_evt ##1 wake_req);
endmodule

/* apm_ctrl_test.sv */
`timescale 1ns/1ps
`include "apm_cfg.svh"
module apm_ctrl_test;
    import apm_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    apm_wb_req_s wb_req = '0;
    logic        cpu_sleep = 1'b0, cpu_idle = 1'b0, mod_dis = 1'b0;
    logic        rc_osc_pin = 1'b0, rc_run = 1'b0;
    logic [1:0]  rc_cnt = 2'h0;
    logic [15:0] ain_diff = 16'h0, aref_span = 16'h1;
    logic [31:0] wb_dat_o, seed = 32'h96ea;
    logic        wb_ack_o, wake_req, sample_switch, conv_clk_en, conv_done_irq;
    logic [15:0] pin_direction_bits, analog_select;
    logic [15:0] td[5] = '{16'h0, 16'h0, 16'h1, 16'h4321, 16'hffff};
    logic [15:0] ts[5] = '{16'h0, 16'h0, 16'hffff, 16'h4321, 16'h8000};
    logic [63:0] expq[$];
    logic [63:0] mon;
    logic [11:0] last;
    int          n_fail = 0, n_compared = 0;

    apm_ctrl dut (.clock(clock), .srst(srst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
        .module_disable_bit(mod_dis), .wake_req(wake_req), .rc_osc_pin(rc_osc_pin),
        .ain_diff(ain_diff), .aref_span(aref_span), .sample_switch(sample_switch),
        .conv_clk_en(conv_clk_en), .conv_done_irq(conv_done_irq),
        .pin_direction_bits(pin_direction_bits), .analog_select(analog_select));

    // System clock
    always #5 clock = ~clock;

    // Slow converter clock, one rising edge every four system cycles
    always @(posedge clock)
    begin
        rc_cnt <= rc_cnt + 2'h1;
        rc_osc_pin <= rc_run & rc_cnt[1];
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Code is floor of difference over span, clipped at all ones
    function automatic logic [11:0] code(input logic ten, input logic [15:0] d,
                                         input logic [15:0] s);
        logic [31:0] q;
        logic [11:0] mx;
        mx = ten ? 12'h3ff : 12'hfff;
        q = ({16'h0, d} << (ten ? 10 : 12)) / {16'h0, s};
        return (q > {20'h0, mx}) ? mx : q[11:0];
    endfunction

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %0s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rd(input logic [31:0] e, input logic [31:0] m);
        n_compared++;
        if ((wb_dat_o & m) !== (e & m))
        begin
            n_fail++;
            $display("[ERR] rdata expected %h seen %h", e & m, wb_dat_o & m);
        end
    endtask

    // One classic bus cycle; for reads d is the expected data under mask m
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m = 32'h0, input logic [3:0] s = 4'hf);
        expq.push_back({d, m});
        @(posedge clock);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
        @(posedge clock);
        while (wb_ack_o !== 1'b1)
            @(posedge clock);
        wb_req <= '0;
        @(posedge clock);
    endtask

    // Clear, then configure; a conversion launches on its own when cfg selects the automatic trigger
    task automatic run(input logic [31:0] cfg, input logic [15:0] d, input logic [15:0] s);
        ain_diff <= d;
        aref_span <= s;
        bus(1'b1, `APM_OFS_CTRL, 32'h0);
        bus(1'b1, `APM_OFS_CTRL, cfg);
        last = code(cfg[10], d, s);
    endtask

    // Takes the oldest note at each acknowledge and compares read data
    always @(posedge clock)
        if (wb_ack_o === 1'b1 && expq.size() > 0)
        begin
            mon = expq.pop_front();
            if (mon[31:0] != 32'h0)
                chk_rd(mon[63:32], mon[31:0]);
        end

    // Watchdog against a hang
    initial
    begin
        repeat (30000) @(posedge clock);
        n_fail++;
        $display("[ERR] watchdog expected finish seen timeout");
        end_sim();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        chk_pin("pin_dir", 16'hffff, pin_direction_bits);
        chk_pin("ana_sel", 16'hffff, analog_select);
        bus(1'b0, `APM_OFS_CTRL, 32'h0, '1);
        bus(1'b0, `APM_OFS_STATUS, 32'h0, '1);
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            seed = lfsr(seed);
            run(32'h8078 | {21'h0, i[0], 10'h0}, (i < 2) ? seed[15:0] : td[i],
                (i < 2) ? (seed[31:16] | 16'h8000) : ts[i]);
            for (int k = 0; k < 100 && sample_switch !== 1'b1; k++)
                @(posedge clock);
            chk_pin("sample", 16'h1, {15'h0, sample_switch});
            for (int k = 0; k < 1500 && conv_done_irq !== 1'b1; k++)
                @(posedge clock);
            chk_pin("done_irq", 16'h1, {15'h0, conv_done_irq});
            bus(1'b0, `APM_OFS_RESULT, {20'h0, last}, '1);
        end
        run(32'h8008, 16'h3000, 16'h8000);
        bus(1'b1, `APM_OFS_CTRL, 32'h800a);
        repeat (40) @(posedge clock);
        bus(1'b1, `APM_OFS_CTRL, 32'h8008);
        for (int k = 0; k < 500 && conv_done_irq !== 1'b1; k++)
            @(posedge clock);
        chk_pin("done_irq", 16'h1, {15'h0, conv_done_irq});
        bus(1'b0, `APM_OFS_RESULT, {20'h0, last}, '1);
        $display("test transfer done");
        run(32'h8078, 16'h1000, 16'h8000);
        cpu_idle <= 1'b1;
        for (int k = 0; k < 1500 && wake_req !== 1'b1; k++)
            @(posedge clock);
        chk_pin("wake", 16'h1, {15'h0, wake_req});
        bus(1'b0, `APM_OFS_RESULT, {20'h0, last}, '1);
        cpu_idle <= 1'b0;
        $display("test idle run done");
        for (int j = 0; j < 2; j++)
        begin
            run(32'h8070 | {18'h0, j[0], 13'h0}, 16'h2000, 16'h8000);
            repeat (500) @(posedge clock);
            cpu_sleep <= !j[0];
            cpu_idle <= j[0];
            repeat (3) @(posedge clock);
            chk_pin("clk_en", 16'h0, {15'h0, conv_clk_en});
            bus(1'b0, `APM_OFS_STATUS, 32'h9, 32'hb);
            bus(1'b0, `APM_OFS_CTRL, 32'h8070 | {18'h0, j[0], 13'h0}, '1);
            cpu_sleep <= 1'b0;
            cpu_idle <= 1'b0;
            repeat (600) @(posedge clock);
            bus(1'b0, `APM_OFS_STATUS, 32'h9, 32'hb);
        end
        $display("test abort done");
        rc_run <= 1'b1;
        run(32'h8074, 16'h0800, 16'h8000);
        cpu_sleep <= 1'b1;
        repeat (400) @(posedge clock);
        bus(1'b0, `APM_OFS_STATUS, 32'h10, 32'h10);
        bus(1'b0, `APM_OFS_CTRL, 32'h8001, 32'h8001);
        bus(1'b0, `APM_OFS_RESULT, {20'h0, last}, '1);
        chk_pin("wake", 16'h0, {15'h0, wake_req});
        cpu_sleep <= 1'b0;
        run(32'h807c, 16'h0800, 16'h8000);
        cpu_sleep <= 1'b1;
        for (int k = 0; k < 1000 && wake_req !== 1'b1; k++)
            @(posedge clock);
        chk_pin("wake", 16'h1, {15'h0, wake_req});
        cpu_sleep <= 1'b0;
        rc_run <= 1'b0;
        repeat (3) @(posedge clock);
        chk_pin("wake", 16'h0, {15'h0, wake_req});
        $display("test rc sleep done");
        bus(1'b1, `APM_OFS_PINDIR, 32'h1234);
        bus(1'b1, `APM_OFS_PINDIR, 32'hffff, 32'h0, 4'hc);
        bus(1'b0, `APM_OFS_PINDIR, 32'h1234, '1);
        bus(1'b0, 8'h20, 32'h0, '1);
        bus(1'b1, `APM_OFS_CTRL, 32'h0);
        mod_dis <= 1'b1;
        bus(1'b1, `APM_OFS_CTRL, 32'h8078);
        bus(1'b0, `APM_OFS_CTRL, 32'h0, '1);
        chk_pin("clk_en", 16'h0, {15'h0, conv_clk_en});
        mod_dis <= 1'b0;
        bus(1'b0, `APM_OFS_CTRL, 32'h0, '1);
        $display("test disable done");
        bus(1'b1, `APM_OFS_CTRL, 32'h8078);
        repeat (500) @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        chk_pin("pin_dir", 16'hffff, pin_direction_bits);
        bus(1'b0, `APM_OFS_STATUS, 32'h0, '1);
        bus(1'b0, `APM_OFS_CTRL, 32'h0, '1);
        bus(1'b0, `APM_OFS_RESULT, {20'h0, last}, '1);
        $display("test reset mid run done");
        end_sim();
    end
endmodule
